// file: hw/cwe_top.sv
// Function
// - recognise wait opcode three, class zero
// - wait for next vblank start pipe
// - wait for next hblank start pipe
// - wait for next vblank event pipe
// - wait while plane flip is pending
// - wait while overlay flip is pending
// - wait while selected condition code set
// - wait while refresh inside scan window
// - outside window or none: no effect
// - ring leaves arbitration while compressor busy
//
// Local design decisions: register access over APB and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module cwe_top
    import cwe_pkg::*;
(
    input  wire logic        MCLK_I,
    input  wire logic        ARST_N_I,
    input  wire logic        CE_I,
    input  wire logic        PSEL_I,
    input  wire logic        PENABLE_I,
    input  wire logic        PWRITE_I,
    input  wire logic [11:0] PADDR_I,
    input  wire logic [31:0] PWDATA_I,
    output logic [31:0]      PRDATA_O,
    output logic             PREADY_O,
    output logic             PSLVERR_O,
    input  wire cwe_evt_t    EVT_I,
    input  wire logic        CMD_VALID_I,
    input  wire logic [31:0] CMD_I,
    input  wire logic        CMD_BATCH_I,
    output logic             CMD_READY_O,
    output logic             STALL_O,
    output logic             RING_ARB_OUT_O,
    output logic             ARB_HALT_O
);
    cwe_state_t  state;
    logic [31:0] cmd;
    logic        from_batch;
    logic        evt_done;
    logic        is_wait;
    logic        resv;
    logic        ctl_enable;
    logic        reserved_seen;
    logic        apb_cmd;
    logic [31:0] cur_word;
    logic        cur_valid;
    logic        cur_batch;
    logic        sw_take;
    logic        wr_acc;
    logic        rd_acc;
    logic [31:0] next_rdata;
    logic        next_err;

    assign wr_acc = PSEL_I && PENABLE_I && PWRITE_I;
    assign rd_acc = PSEL_I && PENABLE_I && !PWRITE_I;
    // software may inject a command through the cmd register
    assign sw_take = wr_acc && (PADDR_I == ADDR_CMD) && CE_I;
    assign cur_valid = CMD_VALID_I || sw_take;
    assign cur_word = sw_take ? PWDATA_I : CMD_I;
    assign cur_batch = sw_take ? PWDATA_I[0] && 1'b0 : CMD_BATCH_I;

    cwe_decode u_dec (
        .cmd_i      (cur_word),
        .is_wait_o  (is_wait),
        .reserved_o (resv)
    );

    // condition that keeps an armed wait stalled; not used while an edge wait is armed
    function automatic logic level_hold(input logic [31:0] c,
                                        input cwe_evt_t e);
        logic [3:0] sel;
        logic       cc_hit;
        sel = c[CC_HI:CC_LO];
        cc_hit = 1'b0;
        if (sel >= 4'h1 && sel <= CC_MAX) begin
            cc_hit = e.ccode[sel];
        end
        level_hold = (c[B_FLIP_A] & e.flip_pend[0])
                   | (c[B_FLIP_B] & e.flip_pend[1])
                   | (c[B_FLIP_C] & e.flip_pend[2])
                   | (c[B_OVL_FLIP] & e.ovl_flip)
                   | (c[B_SCAN_A] & e.scan_in_a)
                   | (c[B_SCAN_B] & e.scan_in_b)
                   | cc_hit;
    endfunction : level_hold

    // edge waits that have been armed by the command
    function automatic logic edge_armed(input logic [31:0] c,
                                        input cwe_evt_t e);
        edge_armed = c[B_VBS_A] | c[B_VBS_B] | c[B_HBS_A] | c[B_HBS_B]
                   | (c[B_VBE_A] & e.vbl_en_a)
                   | (c[B_VBE_B] & e.vbl_en_b);
    endfunction : edge_armed

    // any armed edge event seen this cycle ends the wait
    function automatic logic edge_hit(input logic [31:0] c,
                                      input cwe_evt_t e);
        edge_hit = (c[B_VBS_A] & e.vbs_a) | (c[B_VBS_B] & e.vbs_b)
                 | (c[B_HBS_A] & e.hbs_a) | (c[B_HBS_B] & e.hbs_b)
                 | (c[B_VBE_A] & e.vbe_a & e.vbl_en_a)
                 | (c[B_VBE_B] & e.vbe_b & e.vbl_en_b);
    endfunction : edge_hit

    // edge waits end on an event; level waits end when condition clears
    assign evt_done = edge_armed(cmd, EVT_I) ? edge_hit(cmd, EVT_I)
                                             : !level_hold(cmd, EVT_I);

    // wait state machine
    always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            state <= ST_IDLE;
            cmd <= 32'h0000_0000;
            from_batch <= 1'b0;
        end else if (CE_I) begin
            case (state)
                ST_IDLE: begin
                    if (cur_valid && is_wait && ctl_enable) begin
                        cmd <= cur_word;
                        from_batch <= cur_batch;
                        // no active condition: behaves as no-op
                        if (cur_word[B_FBC_IDLE] && EVT_I.fbc_busy) begin
                            state <= ST_FBC;
                        end else if (edge_armed(cur_word, EVT_I) ||
                                     level_hold(cur_word, EVT_I)) begin
                            state <= ST_WAIT;
                        end
                    end
                end
                ST_FBC: begin
                    if (!EVT_I.fbc_busy) begin
                        if (edge_armed(cmd, EVT_I) ||
                            level_hold(cmd, EVT_I)) begin
                            state <= ST_WAIT;
                        end else begin
                            state <= ST_IDLE;
                        end
                    end
                end
                ST_WAIT: begin
                    if (evt_done) begin
                        state <= ST_IDLE;
                    end
                end
                default: state <= ST_IDLE;
            endcase
        end
    end

    // stream accepts commands only when not waiting
    assign CMD_READY_O = (state == ST_IDLE);
    assign STALL_O = (state != ST_IDLE);
    assign RING_ARB_OUT_O = (state == ST_FBC);
    // batch waits freeze arbitration; ring waits leave others running
    assign ARB_HALT_O = (state != ST_IDLE) && from_batch;

    // control register and reserved-bit sticky flag
    always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            ctl_enable <= 1'b1;
            reserved_seen <= 1'b0;
        end else if (CE_I) begin
            if (wr_acc && PADDR_I == ADDR_CTRL) begin
                ctl_enable <= PWDATA_I[0];
            end
            // set wins over the clear in the same cycle
            if (state == ST_IDLE && cur_valid && is_wait && resv) begin
                reserved_seen <= 1'b1;
            end else if (wr_acc && PADDR_I == ADDR_STATUS &&
                         PWDATA_I[8]) begin
                reserved_seen <= 1'b0;
            end
        end
    end

    // apb read mux
    always_comb begin
        next_rdata = 32'h0000_0000;
        next_err = 1'b0;
        if (PADDR_I == ADDR_CMD) begin
            next_rdata = 32'h0000_0000;
        end else if (PADDR_I == ADDR_STATUS) begin
            next_rdata = {23'h00_0000, reserved_seen, 3'h0, ARB_HALT_O,
                          RING_ARB_OUT_O, 1'b0, state};
        end else if (PADDR_I == ADDR_CTRL) begin
            next_rdata = {31'h0000_0000, ctl_enable};
        end else if (PADDR_I == ADDR_LAST) begin
            next_rdata = cmd;
        end else begin
            next_err = 1'b1;
        end
    end

    assign apb_cmd = PSEL_I && PENABLE_I;
    // read data registered in setup so access phase answers at once
    always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            PRDATA_O <= 32'h0000_0000;
        end else if (CE_I && PSEL_I && !PENABLE_I && !PWRITE_I) begin
            PRDATA_O <= next_rdata;
        end
    end
    // cmd writes stall while a wait is in progress
    assign PREADY_O = !(PADDR_I == ADDR_CMD && PWRITE_I &&
                        state != ST_IDLE) && CE_I;
    assign PSLVERR_O = apb_cmd && next_err;

    // stalled stream holds while an armed level condition persists
    stall_hold_a: assert property (@(posedge MCLK_I)
        disable iff (!ARST_N_I)
        (state == ST_WAIT && !edge_armed(cmd, EVT_I) &&
         level_hold(cmd, EVT_I) && CE_I) |=> state == ST_WAIT)
        else $error("wait ended while condition active");
    vbs_end_a: assert property (@(posedge MCLK_I) disable iff (!ARST_N_I)
        (state == ST_WAIT && cmd[B_VBS_A] && EVT_I.vbs_a && CE_I)
        |=> state == ST_IDLE)
        else $error("vblank start did not end wait");
    hbs_end_a: assert property (@(posedge MCLK_I) disable iff (!ARST_N_I)
        (state == ST_WAIT && cmd[B_HBS_B] && EVT_I.hbs_b && CE_I)
        |=> state == ST_IDLE)
        else $error("hblank start did not end wait");
    vbe_end_a: assert property (@(posedge MCLK_I) disable iff (!ARST_N_I)
        (state == ST_WAIT && cmd[B_VBE_A] && EVT_I.vbe_a &&
         EVT_I.vbl_en_a && CE_I) |=> state == ST_IDLE)
        else $error("vblank event did not end wait");
    flip_hold_a: assert property (@(posedge MCLK_I) disable iff (!ARST_N_I)
        (state == ST_WAIT && cmd[B_FLIP_A] && EVT_I.flip_pend[0] &&
         !edge_armed(cmd, EVT_I)) |-> !CMD_READY_O)
        else $error("flip pending not held");
    ovl_hold_a: assert property (@(posedge MCLK_I) disable iff (!ARST_N_I)
        (state == ST_WAIT && cmd[B_OVL_FLIP] && EVT_I.ovl_flip &&
         !edge_armed(cmd, EVT_I)) |-> STALL_O)
        else $error("overlay flip not held");
    scan_pass_a: assert property (@(posedge MCLK_I) disable iff (!ARST_N_I)
        (state == ST_IDLE && CE_I && cur_valid && is_wait && ctl_enable &&
         cur_word[B_SCAN_A] && !EVT_I.scan_in_a &&
         (cur_word & 32'h001F_FFFE) == 32'h0000_0002) |=> state == ST_IDLE)
        else $error("scan window wait not a no-op");
    fbc_arb_a: assert property (@(posedge MCLK_I) disable iff (!ARST_N_I)
        (state == ST_FBC && EVT_I.fbc_busy && CE_I) |=> RING_ARB_OUT_O)
        else $error("ring returned while compressor busy");
    batch_halt_a: assert property (@(posedge MCLK_I) disable iff (!ARST_N_I)
        ARB_HALT_O |-> (from_batch && STALL_O))
        else $error("arbitration halted without batch wait");
endmodule : cwe_top
`default_nettype wire

// file: include/cwe_pkg.sv
`default_nettype none
package cwe_pkg;
    // command word decode
    localparam int unsigned TYPE_HI = 31;
    localparam int unsigned TYPE_LO = 29;
    localparam int unsigned OPC_HI = 28;
    localparam int unsigned OPC_LO = 23;
    localparam logic [2:0] CMD_CLASS_MI = 3'h0;
    localparam logic [5:0] OPC_EVENT_WAIT = 6'h03;
    // enable bit positions
    localparam int unsigned B_VBS_B = 18;
    localparam int unsigned B_VBS_A = 17;
    localparam int unsigned B_OVL_FLIP = 16;
    localparam int unsigned B_HBS_B = 14;
    localparam int unsigned B_HBS_A = 13;
    localparam int unsigned CC_HI = 12;
    localparam int unsigned CC_LO = 9;
    localparam int unsigned B_FLIP_C = 8;
    localparam int unsigned B_VBE_B = 7;
    localparam int unsigned B_FLIP_B = 6;
    localparam int unsigned B_SCAN_B = 5;
    localparam int unsigned B_FBC_IDLE = 4;
    localparam int unsigned B_VBE_A = 3;
    localparam int unsigned B_FLIP_A = 2;
    localparam int unsigned B_SCAN_A = 1;
    localparam logic [3:0] CC_MAX = 4'h5;
    // apb register map (byte addresses)
    localparam logic [11:0] ADDR_CMD = 12'h000;
    localparam logic [11:0] ADDR_STATUS = 12'h004;
    localparam logic [11:0] ADDR_CTRL = 12'h008;
    localparam logic [11:0] ADDR_LAST = 12'h00C;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

    // display side event and condition inputs
    typedef struct packed {
        logic       vbs_a;    // start of vblank pulses
        logic       vbs_b;
        logic       hbs_a;    // start of hblank pulses
        logic       hbs_b;
        logic       vbe_a;    // vblank event pulses
        logic       vbe_b;
        logic       vbl_en_a; // vblank enable bit of pipe status
        logic       vbl_en_b;
        logic [2:0] flip_pend; // planes c,b,a
        logic       ovl_flip;
        logic       scan_in_a; // refresh inside programmed window
        logic       scan_in_b;
        logic       fbc_busy;
        logic [5:1] ccode;    // condition codes 1..5
    } cwe_evt_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_WAIT = 2'b01,
        ST_FBC  = 2'b10
    } cwe_state_t;
endpackage : cwe_pkg
`default_nettype wire

// file: hw/cwe_decode.sv
`timescale 1ns/1ps
`default_nettype none
module cwe_decode
    import cwe_pkg::*;
(
    input  wire logic [31:0] cmd_i,
    output logic             is_wait_o,
    output logic             reserved_o
);
    // command class and opcode match
    assign is_wait_o = (cmd_i[TYPE_HI:TYPE_LO] == CMD_CLASS_MI) &&
                       (cmd_i[OPC_HI:OPC_LO] == OPC_EVENT_WAIT);
    // reserved field or reserved condition-code select
    assign reserved_o = (|cmd_i[22:19]) | cmd_i[15] | cmd_i[0] |
                        (cmd_i[CC_HI:CC_LO] > CC_MAX);
endmodule : cwe_decode
`default_nettype wire

// file: test/cwe_disp_model.sv
`timescale 1ns/1ps
`default_nettype none
module cwe_disp_model
    import cwe_pkg::*;
(
    input  wire logic       clk_i,
    input  wire logic       rst_n_i,
    input  wire logic [5:0] pulse_i,
    input  wire cwe_evt_t   lvl_i,
    output cwe_evt_t        evt_o
);
    // display side: pulses last one cycle, levels follow the bench
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            evt_o <= '0;
        end else begin
            evt_o <= lvl_i;
            {evt_o.vbs_a, evt_o.vbs_b, evt_o.hbs_a, evt_o.hbs_b,
             evt_o.vbe_a, evt_o.vbe_b} <= pulse_i;
            // vblank enable kept set so vblank waits are armed
            evt_o.vbl_en_a <= 1'b1;
            evt_o.vbl_en_b <= 1'b1;
        end
    end
endmodule : cwe_disp_model
`default_nettype wire

// file: test/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb
    import cwe_pkg::*;
;
    localparam logic [31:0] WAIT = 32'h0180_0000;
    logic        mclk, arst_n, psel, penable, pwrite, valid, batch;
    logic        pready, pslverr, ready, stall, arb_out, halt, err;
    logic        ce;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, cmd, rd, c;
    logic [5:0]  pulse;
    cwe_evt_t    lvl, evt;
    int          miscompares = 0;
    int          total_checks = 0;
    int          ebit[6] = '{17, 18, 13, 14, 3, 7};
    int          lbit[6] = '{2, 6, 8, 16, 1, 5};

    cwe_top dut_u (.MCLK_I(mclk), .ARST_N_I(arst_n), .CE_I(ce),
        .PSEL_I(psel), .PENABLE_I(penable), .PWRITE_I(pwrite),
        .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
        .PREADY_O(pready), .PSLVERR_O(pslverr), .EVT_I(evt),
        .CMD_VALID_I(valid), .CMD_I(cmd), .CMD_BATCH_I(batch),
        .CMD_READY_O(ready), .STALL_O(stall),
        .RING_ARB_OUT_O(arb_out), .ARB_HALT_O(halt));
    cwe_disp_model mdl_u (.clk_i(mclk), .rst_n_i(arst_n),
        .pulse_i(pulse), .lvl_i(lvl), .evt_o(evt));

    // free-running clock, 4 ns period
    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value at %0t: got %h exp %h", $time, got, exp);
        end
    endtask : chk

    // a wait that ran out of its bound without the answer counts as wrong
    task automatic tmo(input logic ok);
        if (!ok) begin
            miscompares++;
            finish_test();
        end
    endtask : tmo

    task automatic cyc(input int k);
        repeat (k) @(posedge mclk);
    endtask : cyc

    // apb: hold request until pready is seen high at an edge
    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        do begin
            @(posedge mclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        tmo(pready === 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // idle edge so a following call never reassigns psel at once
        @(posedge mclk);
    endtask : apb

    // command stream: taken on the edge where ready is high
    task automatic send(input logic [31:0] w, input logic b);
        int n;
        n = 0;
        valid <= 1'b1;
        cmd <= w;
        batch <= b;
        do begin
            @(posedge mclk);
            n++;
        end while (ready !== 1'b1 && n < 50);
        tmo(ready === 1'b1);
        valid <= 1'b0;
    endtask : send

    // expected display condition for level wait case i
    function automatic cwe_evt_t cond(input int i);
        cwe_evt_t e;
        e = '0;
        case (i)
            0, 1, 2: e.flip_pend = 3'(1 << i);
            3: e.ovl_flip = 1'b1;
            4: e.scan_in_a = 1'b1;
            5: e.scan_in_b = 1'b1;
            default: e.ccode = 5'(1 << (i - 6));
        endcase
        return e;
    endfunction : cond

    task automatic finish_test();
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : finish_test

    initial begin
        {psel, penable, pwrite, valid, batch} = '0;
        ce = 1'b1;
        {paddr, pwdata, cmd, pulse} = '0;
        lvl = '0;
        arst_n = 1'b0;
        void'($urandom(32'hd9a3eebe));
        cyc(2);
        arst_n <= 1'b1;
        apb(1'b0, ADDR_STATUS, 32'h0);
        chk(rd, 32'h0);
        apb(1'b0, 12'h010 + 12'(($urandom % 64) << 2), 32'h0);
        chk(32'(err), 32'h1);
        // other commands and other opcodes pass with no stall
        for (int i = 0; i < 8; i++) begin
            c = $urandom;
            c[31:23] = (i[0]) ? 9'h103 : {3'h0, 6'($urandom % 3)};
            send(c, 1'b0);
            cyc(2);
            chk(stall, 0);
        end
        $display("done: decode");
        // edge waits ignore other events, end on their own
        for (int i = 0; i < 6; i++) begin
            send(WAIT | (32'h1 << ebit[i]), 1'b0);
            pulse <= 6'h20 >> ((i + 1) % 6);
            cyc(1);
            pulse <= '0;
            cyc(3);
            chk({stall, ready}, 2'b10);
            pulse <= 6'h20 >> i;
            cyc(1);
            pulse <= '0;
            cyc(3);
            chk(stall, 0);
        end
        $display("done: edge waits");
        // level waits: no-op when inactive, hold while active
        for (int i = 0; i < 11; i++) begin
            c = (i < 6) ? WAIT | (32'h1 << lbit[i]) : WAIT | 32'((i - 5) << 9);
            send(c, 1'b0);
            cyc(3);
            chk(stall, 0);
            lvl <= cond(i);
            cyc(2);
            send(c, 1'b0);
            cyc(3);
            chk(stall, 1);
            lvl <= '0;
            cyc(4);
            chk(stall, 0);
        end
        apb(1'b0, ADDR_LAST, 32'h0);
        chk(rd, c);
        // reserved condition codes never wait and are flagged
        lvl.ccode <= 5'h1f;
        send(WAIT | 32'((6 + $urandom % 10) << 9), 1'b0);
        cyc(3);
        chk(stall, 0);
        apb(1'b0, ADDR_STATUS, 32'h0);
        chk(rd[8], 1'b1);
        lvl <= '0;
        $display("done: level waits");
        cyc(1);
        // compressor wait from ring, then batch wait halts arbitration
        lvl.fbc_busy <= 1'b1;
        cyc(2);
        send(WAIT | 32'h10, 1'b0);
        cyc(3);
        chk({arb_out, halt}, 2'b10);
        lvl <= '0;
        cyc(4);
        chk({arb_out, stall}, 2'b00);
        apb(1'b1, ADDR_CMD, WAIT | 32'h2_0000);
        cyc(3);
        chk({stall, halt}, 2'b10);
        pulse <= 6'h20;
        cyc(1);
        pulse <= '0;
        cyc(3);
        send(WAIT | 32'h2_0000, 1'b1);
        cyc(3);
        chk({stall, halt}, 2'b11);
        pulse <= 6'h20;
        cyc(1);
        pulse <= '0;
        cyc(3);
        chk({stall, halt}, 2'b00);
        $display("done: arbitration");
        // frozen clock enable: an event pulse is missed, wait holds
        send(WAIT | 32'h2_0000, 1'b0);
        cyc(2);
        ce <= 1'b0;
        pulse <= 6'h20;
        cyc(1);
        pulse <= '0;
        cyc(3);
        chk(stall, 1);
        ce <= 1'b1;
        pulse <= 6'h20;
        cyc(1);
        pulse <= '0;
        cyc(3);
        chk({stall, ready}, 2'b01);
        $display("done: clock enable");
        finish_test();
    end
endmodule : tb
`default_nettype wire
